// File: rtl/aec_pkg.sv
// constants, types and behaviour notes for the asynchronous event counter
// Notes on behaviour
// RULE_01 - sixteen-bit counter from high and low bytes, wraps after 65536 events
// RULE_02 - high and low bytes can run as two independent 8-bit channels
// RULE_03 - external events count regardless of base clock activity; here the pins are sampled on clk, so events count only while clk runs
// RULE_04 - counting allowed only while gate pin or gate pwm output is high
// RULE_05 - gate interrupt on selected edge or both edges of the gate signal
// RULE_06 - gate pin interrupt usable alone when counters are idle
// RULE_07 - gate pwm toggles counting enable automatically in a fixed cycle
// RULE_08 - each counter picks event pin or clock divided by 2, 4 or 8
// RULE_09 - both-edge counting available on high and low event pins
// RULE_10 - software can reset each counter and halt its counting
// RULE_11 - overflow of a counter raises an interrupt request
// RULE_12 - module standby bit stops this block independently
// RULE_13 - pwm period high and low registers, read/write, reset to FF
// RULE_14 - software keeps period registers unchanged while pwm enable is set
// RULE_15 - pwm data high and low registers, write-only, reset to zero
// RULE_16 - software keeps data registers unchanged while pwm enable is set
// RULE_17 - edge select register holds three edge fields and pwm enable at bit 1
// RULE_18 - high pin edge bits 7:6: 00 falling, 01 rising, 10 both
// RULE_19 - low pin bits 5:4 and gate bits 3:2 use the same encoding
// RULE_20 - pwm enable 0 gates by pin; 1 runs pwm and deselects pin
// RULE_21 - overflow flag set on FF to 00, cleared by read-1 then write-0
// RULE_22 - channel mode 0 cascades bytes; high flag marks FFFF to 0000
// RULE_23 - counts and overflows are captured in the system clock domain
package aec_pkg;
  localparam logic [15:0] ADDR_PERIOD_HIGH = 16'hFF8C;
  localparam logic [15:0] ADDR_PERIOD_LOW = 16'hFF8D;
  localparam logic [15:0] ADDR_DATA_HIGH = 16'hFF8E;
  localparam logic [15:0] ADDR_DATA_LOW = 16'hFF8F;
  localparam logic [15:0] ADDR_EDGE_SEL = 16'hFF92;
  localparam logic [15:0] ADDR_CTRL = 16'hFF94;
  localparam logic [15:0] ADDR_CTRL_STATUS = 16'hFF95;
  localparam logic [15:0] ADDR_COUNT_HIGH = 16'hFF96;
  localparam logic [15:0] ADDR_COUNT_LOW = 16'hFF97;
  localparam logic [15:0] ADDR_CLOCK_STOP = 16'hFFFB;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CLOCK_STOP = 8'hFF;
  // edge select fields
  localparam int EDGE_HIGH_LSB = 6;
  localparam int EDGE_LOW_LSB = 4;
  localparam int EDGE_GATE_LSB = 2;
  localparam int PWM_ENABLE_BIT = 1;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  // control fields
  localparam int CLK_HIGH_LSB = 6;
  localparam int CLK_LOW_LSB = 4;
  localparam int PWM_CLK_LSB = 1;
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_DIV2 = 2'h1;
  localparam logic [1:0] SRC_DIV4 = 2'h2;
  // control/status fields, clock stop standby bit and count constants
  localparam int OVF_HIGH_BIT = 7;
  localparam int OVF_LOW_BIT = 6;
  localparam int SPLIT_BIT = 4;
  localparam int RUN_HIGH_BIT = 3;
  localparam int RUN_LOW_BIT = 2;
  localparam int RELEASE_HIGH_BIT = 1;
  localparam int RELEASE_LOW_BIT = 0;
  localparam int STANDBY_BIT = 3;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [5:0] PRESCALE_ONE = 6'h01;

  typedef struct packed {
    logic [15:0] address;
    logic read;
    logic write;
    logic [7:0] writedata;
  } aec_bus_req_t;

  typedef struct packed {
    logic [7:0] periodHigh;
    logic [7:0] periodLow;
    logic [7:0] dataHigh;
    logic [7:0] dataLow;
    logic [7:0] edgeSel;
    logic [7:0] ctrl;
    logic [7:0] ctrlStatus;
    logic [7:0] clockStop;
    logic [7:0] countHigh;
    logic [7:0] countLow;
    logic [5:0] prescale;
    logic [15:0] pwmCount;
    logic pwmOut;
    logic evHighPrev;
    logic evLowPrev;
    logic gatePrev;
    logic ovfHighArmed;
    logic ovfLowArmed;
    logic [7:0] readData;
    logic readValid;
    logic irqGate;
    logic irqOvfHigh;
    logic irqOvfLow;
    logic pwmPin;
  } aec_state_t;
endpackage

// File: rtl/aec_event_counter.sv
// asynchronous event counter with gating pwm and avalon-mm register slave
`timescale 1ns/100ps
module aec_event_counter (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [7:0] avsWritedata,
  output logic [7:0] avsReaddata,
  output logic avsWaitrequest,
  input wire logic eventInHigh,
  input wire logic eventInLow,
  input wire logic gateIrqPin,
  output logic gatePwmOut,
  output logic irqGate,
  output logic irqOverflowHigh,
  output logic irqOverflowLow
);
  aec_pkg::aec_state_t s_q;
  aec_pkg::aec_state_t s_d;
  aec_pkg::aec_bus_req_t req;

  logic active;
  logic gateLevel;
  logic gateEdge;
  logic tickHigh;
  logic tickLow;
  logic [15:0] cascade;
  logic [15:0] pwmLimit;
  logic pwmTick;
  logic [15:0] count16;
  logic wrapHigh;
  logic wrapLow;

  // ---------------------------------------------------------------
  // edge and source selection
  // ---------------------------------------------------------------
  function automatic logic edgeHit(input logic [1:0] sel, input logic now, input logic prev);
    logic hit;
    hit = 1'b0;
    case (sel)
      aec_pkg::EDGE_FALL: hit = prev & ~now;
      aec_pkg::EDGE_RISE: hit = ~prev & now;
      aec_pkg::EDGE_BOTH: hit = prev ^ now;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic srcTick(input logic [1:0] src, input logic pinHit,
                                   input logic [5:0] pre);
    logic t;
    t = 1'b0;
    case (src)
      aec_pkg::SRC_PIN: t = pinHit;
      aec_pkg::SRC_DIV2: t = pre[0];
      aec_pkg::SRC_DIV4: t = &pre[1:0];
      default: t = &pre[2:0];
    endcase
    return t;
  endfunction

  always_comb begin
    req.address = avsAddress;
    req.read = avsRead;
    req.write = avsWrite;
    req.writedata = avsWritedata;
  end

  always_comb begin
    // standby bit at 0 stops the module, see RULE_12
    active = s_q.clockStop[aec_pkg::STANDBY_BIT];
    // gate is pin when pwm disabled, pwm output otherwise, see RULE_20
    gateLevel = s_q.edgeSel[aec_pkg::PWM_ENABLE_BIT] ? s_q.pwmOut : gateIrqPin;
    // gate interrupt works whether or not counting is used, see RULE_05 and RULE_06
    gateEdge = edgeHit(s_q.edgeSel[aec_pkg::EDGE_GATE_LSB +: 2], gateLevel, s_q.gatePrev);
    // pins sampled on clk; events faster than half clk rate are lost, see RULE_03 and RULE_09
    tickHigh = srcTick(s_q.ctrl[aec_pkg::CLK_HIGH_LSB +: 2],
      edgeHit(s_q.edgeSel[aec_pkg::EDGE_HIGH_LSB +: 2], eventInHigh, s_q.evHighPrev),
      s_q.prescale); // see RULE_08
    tickLow = srcTick(s_q.ctrl[aec_pkg::CLK_LOW_LSB +: 2],
      edgeHit(s_q.edgeSel[aec_pkg::EDGE_LOW_LSB +: 2], eventInLow, s_q.evLowPrev),
      s_q.prescale); // see RULE_08
    // counting only while gate high, see RULE_04
    tickHigh = tickHigh & gateLevel & active & s_q.ctrlStatus[aec_pkg::RUN_HIGH_BIT];
    tickLow = tickLow & gateLevel & active & s_q.ctrlStatus[aec_pkg::RUN_LOW_BIT];
    // pwm clock: prescale bit n pattern gives phi/2 .. phi/64
    case (s_q.ctrl[aec_pkg::PWM_CLK_LSB +: 3])
      3'h0: pwmTick = s_q.prescale[0];
      3'h1: pwmTick = &s_q.prescale[1:0];
      3'h2: pwmTick = &s_q.prescale[2:0];
      3'h3: pwmTick = &s_q.prescale[3:0];
      3'h4: pwmTick = &s_q.prescale[4:0];
      3'h6: pwmTick = &s_q.prescale[4:0];
      default: pwmTick = &s_q.prescale[5:0];
    endcase
    pwmLimit = {s_q.periodHigh, s_q.periodLow};
    cascade = {s_q.countHigh, s_q.countLow};
    count16 = cascade + 16'h0001;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // wrap strobes live only in this process, one driver each
    wrapHigh = 1'b0;
    wrapLow = 1'b0;
    s_d.irqGate = 1'b0;
    s_d.irqOvfHigh = 1'b0;
    s_d.irqOvfLow = 1'b0;
    s_d.readValid = 1'b0;
    s_d.evHighPrev = eventInHigh;
    s_d.evLowPrev = eventInLow;
    s_d.gatePrev = gateLevel;
    s_d.prescale = active ? s_q.prescale + aec_pkg::PRESCALE_ONE : s_q.prescale;

    // gating pwm: high for data counts, low for the rest of the period, see RULE_07
    if (!s_q.edgeSel[aec_pkg::PWM_ENABLE_BIT] || !active) begin
      s_d.pwmCount = 16'h0000;
      s_d.pwmOut = 1'b0;
    end else if (pwmTick) begin
      s_d.pwmCount = (s_q.pwmCount >= pwmLimit) ? 16'h0000 : s_q.pwmCount + 16'h0001;
      s_d.pwmOut = s_d.pwmCount < {s_q.dataHigh, s_q.dataLow};
    end
    s_d.pwmPin = s_d.pwmOut;
    s_d.irqGate = gateEdge & active;

    // counters, see RULE_01 and RULE_02 and RULE_22
    if (s_q.ctrlStatus[aec_pkg::SPLIT_BIT]) begin
      if (tickHigh) begin
        s_d.countHigh = s_q.countHigh + aec_pkg::CNT_ONE;
        wrapHigh = s_q.countHigh == aec_pkg::CNT_MAX;
      end
      if (tickLow) begin
        s_d.countLow = s_q.countLow + aec_pkg::CNT_ONE;
        wrapLow = s_q.countLow == aec_pkg::CNT_MAX;
      end
    end else if (tickLow) begin
      s_d.countHigh = count16[15:8];
      s_d.countLow = count16[7:0];
      wrapHigh = cascade == 16'hFFFF;
      wrapLow = s_q.countLow == aec_pkg::CNT_MAX;
    end
    // software release holds counter at zero, see RULE_10
    if (!s_q.ctrlStatus[aec_pkg::RELEASE_HIGH_BIT]) begin
      s_d.countHigh = aec_pkg::RST_ZERO;
      wrapHigh = 1'b0;
    end
    if (!s_q.ctrlStatus[aec_pkg::RELEASE_LOW_BIT]) begin
      s_d.countLow = aec_pkg::RST_ZERO;
      wrapLow = 1'b0;
    end

    // register slave, one wait cycle on read
    if (req.write) begin
      case (req.address)
        aec_pkg::ADDR_PERIOD_HIGH: s_d.periodHigh = req.writedata; // see RULE_13
        aec_pkg::ADDR_PERIOD_LOW: s_d.periodLow = req.writedata; // see RULE_13
        aec_pkg::ADDR_DATA_HIGH: s_d.dataHigh = req.writedata; // see RULE_15
        aec_pkg::ADDR_DATA_LOW: s_d.dataLow = req.writedata; // see RULE_15
        aec_pkg::ADDR_EDGE_SEL: s_d.edgeSel = req.writedata; // see RULE_17 and RULE_18 and RULE_19
        aec_pkg::ADDR_CTRL: s_d.ctrl = req.writedata;
        aec_pkg::ADDR_CLOCK_STOP: s_d.clockStop = req.writedata;
        aec_pkg::ADDR_CTRL_STATUS: begin
          s_d.ctrlStatus[5:0] = req.writedata[5:0];
          // flag clears only after read-as-1 and write 0, see RULE_21
          if (!req.writedata[aec_pkg::OVF_HIGH_BIT] && s_q.ovfHighArmed) begin
            s_d.ctrlStatus[aec_pkg::OVF_HIGH_BIT] = 1'b0;
          end
          if (!req.writedata[aec_pkg::OVF_LOW_BIT] && s_q.ovfLowArmed) begin
            s_d.ctrlStatus[aec_pkg::OVF_LOW_BIT] = 1'b0;
          end
          s_d.ovfHighArmed = 1'b0;
          s_d.ovfLowArmed = 1'b0;
        end
        default: begin
        end
      endcase
    end
    if (req.read && !s_q.readValid) begin
      s_d.readValid = 1'b1;
      case (req.address)
        aec_pkg::ADDR_PERIOD_HIGH: s_d.readData = s_q.periodHigh;
        aec_pkg::ADDR_PERIOD_LOW: s_d.readData = s_q.periodLow;
        aec_pkg::ADDR_EDGE_SEL: s_d.readData = s_q.edgeSel;
        aec_pkg::ADDR_CTRL: s_d.readData = s_q.ctrl;
        aec_pkg::ADDR_CTRL_STATUS: begin
          s_d.readData = s_q.ctrlStatus;
          s_d.ovfHighArmed = s_q.ctrlStatus[aec_pkg::OVF_HIGH_BIT];
          s_d.ovfLowArmed = s_q.ctrlStatus[aec_pkg::OVF_LOW_BIT];
        end
        // counts are clk-domain registers, so never torn, see RULE_23
        aec_pkg::ADDR_COUNT_HIGH: s_d.readData = s_q.countHigh;
        aec_pkg::ADDR_COUNT_LOW: s_d.readData = s_q.countLow;
        aec_pkg::ADDR_CLOCK_STOP: s_d.readData = s_q.clockStop;
        default: s_d.readData = aec_pkg::RST_ZERO;
      endcase
    end

    // set wins over a clear in the same cycle, see RULE_21 and RULE_22
    if (wrapHigh) begin
      s_d.ctrlStatus[aec_pkg::OVF_HIGH_BIT] = 1'b1;
    end
    if (wrapLow && s_q.ctrlStatus[aec_pkg::SPLIT_BIT]) begin
      s_d.ctrlStatus[aec_pkg::OVF_LOW_BIT] = 1'b1;
    end
    // overflow interrupt pulses, see RULE_11
    s_d.irqOvfHigh = wrapHigh;
    s_d.irqOvfLow = wrapLow & s_q.ctrlStatus[aec_pkg::SPLIT_BIT];
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.periodHigh <= aec_pkg::RST_PERIOD;
      s_q.periodLow <= aec_pkg::RST_PERIOD;
      s_q.dataHigh <= aec_pkg::RST_DATA;
      s_q.dataLow <= aec_pkg::RST_DATA;
      s_q.clockStop <= aec_pkg::RST_CLOCK_STOP;
    end else begin
      s_q <= s_d;
    end
  end

  // period and data writes during pwm run are software's duty, see RULE_14 and RULE_16
  always_comb begin
    avsReaddata = s_q.readData;
    avsWaitrequest = (avsRead & ~s_q.readValid);
    gatePwmOut = s_q.pwmPin;
    irqGate = s_q.irqGate;
    irqOverflowHigh = s_q.irqOvfHigh;
    irqOverflowLow = s_q.irqOvfLow;
  end
endmodule

// File: sim/aec_event_counter_assertions.sv
// port checker for the event counter
`timescale 1ns/100ps
module aec_event_counter_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [7:0] avsReaddata,
  input wire logic avsWaitrequest,
  input wire logic gatePwmOut,
  input wire logic irqGate,
  input wire logic irqOverflowHigh,
  input wire logic irqOverflowLow
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_write_no_wait: assert property (avsWrite |-> !avsWaitrequest)
    else $error("write stalled");
  a_idle_no_wait: assert property (!avsRead |-> !avsWaitrequest)
    else $error("wait without read");
  a_read_first_wait: assert property ($rose(avsRead) |-> avsWaitrequest)
    else $error("read answered at once");
  a_read_one_wait: assert property (avsRead && avsWaitrequest ##1 avsRead |-> !avsWaitrequest)
    else $error("read wait too long");
  a_data_holds: assert property (!avsRead |=> $stable(avsReaddata))
    else $error("read data moved");
  a_gate_irq_pulse: assert property (irqGate |=> !irqGate)
    else $error("gate irq too long");
  a_ovf_high_pulse: assert property (irqOverflowHigh |=> !irqOverflowHigh)
    else $error("high overflow irq too long");
  a_ovf_low_pulse: assert property (irqOverflowLow |=> !irqOverflowLow)
    else $error("low overflow irq too long");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=>
    !(irqGate || irqOverflowHigh || irqOverflowLow || gatePwmOut)) else $error("busy in reset");
  cover property (irqGate);
  cover property (irqOverflowHigh);
  cover property (avsRead && !avsWaitrequest);
endmodule
bind aec_event_counter aec_event_counter_assertions aec_event_counter_assertions_i (
  .clk(clk), .rst(rst), .avsRead(avsRead), .avsWrite(avsWrite), .avsReaddata(avsReaddata),
  .avsWaitrequest(avsWaitrequest), .gatePwmOut(gatePwmOut), .irqGate(irqGate),
  .irqOverflowHigh(irqOverflowHigh), .irqOverflowLow(irqOverflowLow));

// File: sim/aec_event_source.sv
// external event source model for the two event pins
`timescale 1ns/100ps
module aec_event_source (
  input wire logic clk,
  input wire logic go,
  input wire logic sel,
  input wire logic slow,
  input wire logic [3:0] pulses,
  output logic eventHigh = 1'b0,
  output logic eventLow = 1'b0,
  output logic busy
);
  logic [4:0] left = 5'h00;
  logic [1:0] ph = 2'h0;
  logic useLow = 1'b0;
  // slow pace holds each level four cycles, unrelated to any count
  always @(posedge clk) begin
    if (go) begin
      left <= {pulses, 1'b0};
      useLow <= sel;
      ph <= 2'h0;
    end else if (left != 5'h00) begin
      ph <= ph + 2'h1;
      if (ph == {slow, 1'b1}) begin
        ph <= 2'h0;
        left <= left - 5'h01;
        if (useLow) eventLow <= ~eventLow;
        else eventHigh <= ~eventHigh;
      end
    end
  end
  assign busy = (left != 5'h00);
endmodule

// File: sim/tb.sv
// self-checking bench for the event counter
`timescale 1ns/100ps
module tb;
  logic clk, rst, go, sel, slow, evH, evL, gate, busy, waitReq, pwm, irqG, irqH, irqL, pwmPrev;
  logic [3:0] pulses, nP, nQ;
  logic [7:0] rdata, nGate, v, cnt, runLen, hiLen, loLen;
  aec_pkg::aec_bus_req_t req;
  logic [7:0] expQ[$];
  int n_fail, checks_done, seed, i;
  logic [15:0] regA [11] = '{16'hFF8C, 16'hFF8D, 16'hFF8E, 16'hFF8F, 16'hFF92, 16'hFF94,
    16'hFF95, 16'hFF96, 16'hFF97, 16'hFFFB, 16'hFF90};
  logic [7:0] regV [11] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'h00};
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  aec_event_counter aec_event_counter_i (.clk(clk), .rst(rst), .avsAddress(req.address),
    .avsRead(req.read), .avsWrite(req.write), .avsWritedata(req.writedata),
    .avsReaddata(rdata), .avsWaitrequest(waitReq), .eventInHigh(evH), .eventInLow(evL),
    .gateIrqPin(gate), .gatePwmOut(pwm), .irqGate(irqG), .irqOverflowHigh(irqH),
    .irqOverflowLow(irqL));
  aec_event_source aec_event_source_i (.clk(clk), .go(go), .sel(sel), .slow(slow),
    .pulses(pulses), .eventHigh(evH), .eventLow(evL), .busy(busy));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tmo();
    n_fail++;
    final_report();
  endtask
  // ----
  // bus master, answer taken at the edge that sees waitrequest low
  // ----
  task automatic wt();
    int k;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (waitReq === 1'b0) break;
    end
    if (k == 20) tmo();
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, 1'b0, 1'b1, d};
    wt();
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    expQ.push_back(e);
    req <= '{a, 1'b1, 1'b0, 8'h00};
    wt();
  endtask
  task automatic burst(input logic s, input logic [3:0] n, input logic sl);
    int k;
    @(posedge clk);
    {go, sel, pulses, slow} <= {1'b1, s, n, sl};
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (busy === 1'b0) break;
    end
    if (k == 100) tmo();
  endtask
  // ----
  // monitor takes the oldest expected value per completed read
  // ----
  always @(posedge clk) begin
    if (rst === 1'b1) begin
      nGate <= 8'h00;
      runLen <= 8'h00;
      hiLen <= 8'h00;
      loLen <= 8'h00;
    end else begin
      if (irqG === 1'b1) nGate <= nGate + 8'h01;
      // run lengths of the gating pwm output, in clk cycles
      runLen <= (pwm !== pwmPrev) ? 8'h01 : runLen + 8'h01;
      if (pwm !== pwmPrev && pwmPrev === 1'b1) hiLen <= runLen;
      if (pwm !== pwmPrev && pwmPrev === 1'b0) loLen <= runLen;
    end
    pwmPrev <= pwm;
    if (req.read === 1'b1 && waitReq === 1'b0) chk("readdata", expQ.pop_front(), rdata);
  end
  initial begin
    {rst, go, sel, slow, gate, pulses} = {5'h10, 4'h0};
    req = '0;
    n_fail = 0;
    checks_done = 0;
    seed = 94206;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 11; i++) rd(regA[i], regV[i]);
    v = 8'($random(seed));
    wr(16'hFF8C, v);
    rd(16'hFF8C, v);
    wr(16'hFF8F, v);
    rd(16'hFF8F, 8'h00);
    $display("done registers");
    gate <= 1'b1;
    wr(16'hFF95, 8'h0F);
    nP = {1'b0, 3'($random(seed))} + 4'h1;
    cnt = {4'h0, nP};
    burst(1'b1, nP, 1'b0);
    rd(16'hFF97, cnt);
    gate <= 1'b0;
    burst(1'b1, 4'h3, 1'b1);
    rd(16'hFF97, cnt);
    gate <= 1'b1;
    wr(16'hFF92, 8'h20);
    burst(1'b1, 4'h3, 1'b0);
    cnt = cnt + 8'h06;
    rd(16'hFF97, cnt);
    wr(16'hFFFB, 8'hF7);
    burst(1'b1, 4'h2, 1'b0);
    rd(16'hFF97, cnt);
    wr(16'hFFFB, 8'hFF);
    chk("gate irq count", 8'h01, nGate);
    $display("done counting");
    // period 3 and data 1 at phi/2: high 1 tick, low 3 ticks, 2 clk per tick
    wr(16'hFF8C, 8'h00);
    wr(16'hFF8D, 8'h03);
    wr(16'hFF8E, 8'h00);
    wr(16'hFF8F, 8'h01);
    chk("pwm idle", 8'h00, {7'h00, pwm});
    wr(16'hFF92, 8'h22);
    repeat (60) @(posedge clk);
    chk("pwm high run", 8'h02, hiLen);
    chk("pwm low run", 8'h06, loLen);
    wr(16'hFF92, 8'h20);
    repeat (2) @(posedge clk);
    chk("pwm stopped", 8'h00, {7'h00, pwm});
    $display("done pwm");
    wr(16'hFF92, 8'h60);
    rd(16'hFF92, 8'h60);
    wr(16'hFF95, 8'h1F);
    nQ = {1'b0, 3'($random(seed))} + 4'h1;
    burst(1'b0, nQ, 1'b1);
    rd(16'hFF96, {4'h0, nQ});
    // high at phi/4 wraps long before low at phi/8
    wr(16'hFF94, 8'hB0);
    rd(16'hFF94, 8'hB0);
    for (i = 0; i < 2000 && irqH !== 1'b1; i++) @(posedge clk);
    if (i == 2000) tmo();
    rd(16'hFF95, 8'h9F);
    for (i = 0; i < 2000 && irqL !== 1'b1; i++) @(posedge clk);
    if (i == 2000) tmo();
    rd(16'hFF95, 8'hDF);
    wr(16'hFF95, 8'h1C);
    rd(16'hFF95, 8'h1C);
    rd(16'hFF96, 8'h00);
    rd(16'hFF97, 8'h00);
    $display("done overflow");
    final_report();
  end
endmodule
